// *** rtl/rx_filter_pkg.sv ***
package rx_filter_pkg;
   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] IDX_RX_FILTER_CONTROL = 8'h17;
   localparam logic [7:0] IDX_ACK_FILTER_SEED_CONTROL = 8'h2e;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h31;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h32;
   localparam logic [7:0] IDX_PAN_SHORT = 8'h33;
   localparam logic [7:0] IDX_EXT_ADDR_LO = 8'h34;
   localparam logic [7:0] IDX_EXT_ADDR_HI = 8'h35;
   localparam logic [7:0] IDX_RX_STATUS = 8'h36;
   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [7:0] RST_RX_FILTER_CONTROL = 8'h00;
   localparam logic [7:0] RST_ACK_FILTER_SEED_CONTROL = 8'h42;
   localparam logic [7:0] WMASK_RX_FILTER_CONTROL = 8'hf7;
   localparam logic [31:0] RST_PAN_SHORT = 32'hffffffff;
   localparam logic [31:0] RST_EXT_ADDR = 32'h00000000;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int RFC_TX_TIMESTAMP_EN = 7;
   localparam int RFC_RESERVED_RO = 3;
   localparam int RFC_RESERVED_TYPE_FILTER_EN = 5;
   localparam int RFC_RESERVED_TYPE_UPLOAD_EN = 4;
   localparam int RFC_ACK_TURNAROUND_SELECT = 2;
   localparam int RFC_PROMISCUOUS_EN = 1;
   localparam int RFC_SPECIAL_RATE_EN = 0;
   localparam int AFS_FRAME_VERSION_LIMIT_HI = 7;
   localparam int AFS_FRAME_VERSION_LIMIT_LO = 6;
   localparam int AFS_PENDING_DATA_SET = 5;
   localparam int AFS_ACK_DISABLE = 4;
   localparam int AFS_PAN_COORDINATOR_FLAG = 3;
   localparam int IRQ_FRAME_DONE = 0;
   localparam int IRQ_ADDRESS_HIT = 1;
   localparam int IRQ_RESERVED_DROP = 2;
   localparam int IRQ_W = 3;
   // ----------------------------------------
   // Frame control encodings
   // ----------------------------------------
   localparam logic [2:0] FT_BEACON = 3'h0;
   localparam logic [2:0] FT_DATA = 3'h1;
   localparam logic [2:0] FT_ACK = 3'h2;
   localparam logic [2:0] FT_COMMAND = 3'h3;
   localparam logic [1:0] AM_SHORT = 2'h2;
   localparam logic [1:0] AM_EXT = 2'h3;
   localparam logic [1:0] FVL_ANY = 2'h3;
   localparam logic [15:0] BROADCAST_ID = 16'hffff;
   localparam logic [1:0] ACK_FRAME_VERSION = 2'h0;
endpackage

// *** rtl/rx_frame_filter_ack_control.sv ***
// Summary of operation
// - With filtering enabled, reserved-type frames pass the address filter like data frames.
// - With filtering enabled, a reserved-type address match raises the address-hit event.
// - With filtering enabled, reserved-type frame-done needs address match and good FCS.
// - Filtered reserved-type frames are acknowledged only if requested and frame-done was raised.
// - With upload disabled, reserved-type frames are dropped, raising only the reserved-drop event.
// - Upload on, filter off: reserved-type frames get only an FCS check, no addresses.
// - Upload on, filter off: a reserved-type frame with valid FCS raises frame-done.
// - Reserved frame passing the filter and requesting ack is acked unless ack disabled.
// - Promiscuous: every valid-header frame except dropped reserved-type ones raises frame-done; CRC-valid flag still updated.
// - Promiscuous: frames passing the filter are still acked unless ack disabled.
// - Version limit 0..2 accepts versions up to it; 3 accepts any version.
// - Frames above the version limit are rejected and never acknowledged.
// - Generated acknowledgements always carry frame version zero.
// - Coordinator accepts source-only data or command frames when source PAN matches.
// - A present destination PAN must equal our PAN or broadcast.
// - Acknowledgement frames and frames without any address are rejected.
//
// Design decision made here: register access over Wishbone.
module rx_frame_filter_ack_control #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic frm_valid,
   input wire logic frm_phr_ok,
   input wire logic frm_fcs_ok,
   input wire logic [2:0] frm_type,
   input wire logic [1:0] frm_version,
   input wire logic frm_ack_req,
   input wire logic [1:0] frm_dst_mode,
   input wire logic [1:0] frm_src_mode,
   input wire logic [15:0] frm_dst_pan,
   input wire logic [63:0] frm_dst_addr,
   input wire logic [15:0] frm_src_pan,
   input wire logic [7:0] frm_seq,
   output logic frame_done_irq,
   output logic address_hit_irq,
   output logic reserved_drop,
   output logic ack_send,
   output logic [15:0] ack_fcf,
   output logic [7:0] ack_seq,
   output logic irq
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] rx_ctrl_q;
   logic [7:0] seed_ctrl_q;
   logic [rx_filter_pkg::IRQ_W-1:0] irq_status_q;
   logic [rx_filter_pkg::IRQ_W-1:0] irq_enable_q;
   logic [31:0] pan_short_q;
   logic [31:0] ext_lo_q;
   logic [31:0] ext_hi_q;
   logic crc_valid_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [7:0] idx;
   logic req;
   logic wr_en;
   logic [31:0] wmask;
   logic [31:0] wdata_m;

   assign idx = 8'(wb_adr_i[ADDR_W-1:2]);
   assign req = wb_cyc_i && wb_stb_i;
   assign wr_en = req && wb_we_i && ack_q;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdata_m = wb_dat_i & wmask;

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   logic filter_en;
   logic upload_en;
   logic promisc;
   logic [1:0] fv_limit;
   logic pending_set;
   logic ack_dis;
   logic coord;
   logic [15:0] my_pan;
   logic [15:0] my_short;
   logic [63:0] my_ext;

   assign filter_en = rx_ctrl_q[rx_filter_pkg::RFC_RESERVED_TYPE_FILTER_EN];
   assign upload_en = rx_ctrl_q[rx_filter_pkg::RFC_RESERVED_TYPE_UPLOAD_EN];
   assign promisc = rx_ctrl_q[rx_filter_pkg::RFC_PROMISCUOUS_EN];
   assign fv_limit = seed_ctrl_q[rx_filter_pkg::AFS_FRAME_VERSION_LIMIT_HI:rx_filter_pkg::AFS_FRAME_VERSION_LIMIT_LO];
   assign pending_set = seed_ctrl_q[rx_filter_pkg::AFS_PENDING_DATA_SET];
   assign ack_dis = seed_ctrl_q[rx_filter_pkg::AFS_ACK_DISABLE];
   assign coord = seed_ctrl_q[rx_filter_pkg::AFS_PAN_COORDINATOR_FLAG];
   assign my_pan = pan_short_q[31:16];
   assign my_short = pan_short_q[15:0];
   assign my_ext = {ext_hi_q, ext_lo_q};

   // ----------------------------------------
   // Address filter
   // ----------------------------------------
   logic reserved_type;
   logic data_like;
   logic version_ok;
   logic dst_present;
   logic src_present;
   logic pan_ok;
   logic dst_addr_ok;
   logic beacon_ok;
   logic src_only_ok;
   logic addr_match;
   logic done_d;
   logic hit_d;
   logic ack_d;
   logic drop_d;

   assign reserved_type = frm_type[2];
   assign data_like = (frm_type == rx_filter_pkg::FT_DATA) || (frm_type == rx_filter_pkg::FT_COMMAND)
                      || (reserved_type && filter_en);
   assign version_ok = (fv_limit == rx_filter_pkg::FVL_ANY) || (frm_version <= fv_limit);
   assign dst_present = (frm_dst_mode == rx_filter_pkg::AM_SHORT) || (frm_dst_mode == rx_filter_pkg::AM_EXT);
   assign src_present = (frm_src_mode == rx_filter_pkg::AM_SHORT) || (frm_src_mode == rx_filter_pkg::AM_EXT);
   assign pan_ok = (frm_dst_pan == my_pan) || (frm_dst_pan == rx_filter_pkg::BROADCAST_ID);
   assign dst_addr_ok = (frm_dst_mode == rx_filter_pkg::AM_EXT) ? (frm_dst_addr == my_ext)
                        : ((frm_dst_addr[15:0] == my_short) || (frm_dst_addr[15:0] == rx_filter_pkg::BROADCAST_ID));
   assign beacon_ok = (frm_src_pan == my_pan) || (my_pan == rx_filter_pkg::BROADCAST_ID);
   assign src_only_ok = coord && src_present && (frm_src_pan == my_pan);

   always_comb
   begin
      addr_match = 1'b0;
      if (frm_phr_ok && version_ok && frm_type != rx_filter_pkg::FT_ACK && (dst_present || src_present))
      begin
         if (dst_present && !(pan_ok && dst_addr_ok))
            addr_match = 1'b0;
         else if (frm_type == rx_filter_pkg::FT_BEACON)
            addr_match = beacon_ok;
         else if (data_like)
            addr_match = dst_present || src_only_ok;
         else
            addr_match = 1'b0;
      end
   end

   // ----------------------------------------
   // Frame decision
   // ----------------------------------------
   always_comb
   begin
      done_d = 1'b0;
      hit_d = 1'b0;
      ack_d = 1'b0;
      drop_d = 1'b0;
      if (frm_phr_ok && reserved_type && !upload_en)
         drop_d = 1'b1;
      else if (frm_phr_ok && reserved_type && !filter_en)
         done_d = frm_fcs_ok || promisc;
      else if (frm_phr_ok)
      begin
         hit_d = addr_match;
         done_d = (addr_match && frm_fcs_ok) || promisc;
         ack_d = addr_match && frm_fcs_ok && frm_ack_req && !ack_dis
                 && frm_type != rx_filter_pkg::FT_BEACON;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         frame_done_irq <= 1'b0;
         address_hit_irq <= 1'b0;
         reserved_drop <= 1'b0;
         ack_send <= 1'b0;
      end
      else
      begin
         frame_done_irq <= frm_valid && done_d;
         address_hit_irq <= frm_valid && hit_d;
         reserved_drop <= frm_valid && drop_d;
         ack_send <= frm_valid && ack_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack_fcf <= 16'h0000;
         ack_seq <= 8'h00;
      end
      else if (frm_valid && ack_d)
      begin
         ack_fcf <= {2'h0, rx_filter_pkg::ACK_FRAME_VERSION, 7'h00, pending_set, 1'b0, rx_filter_pkg::FT_ACK};
         ack_seq <= frm_seq;
      end
   end

   // Receive status follows every frame with a valid header
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         crc_valid_q <= 1'b0;
      else if (frm_valid && frm_phr_ok)
         crc_valid_q <= frm_fcs_ok;
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [rx_filter_pkg::IRQ_W-1:0] irq_set;
   logic [rx_filter_pkg::IRQ_W-1:0] irq_clr;

   assign irq_set = {reserved_drop, address_hit_irq, frame_done_irq};
   assign irq_clr = (wr_en && idx == rx_filter_pkg::IDX_IRQ_CLEAR) ? wdata_m[rx_filter_pkg::IRQ_W-1:0] : '0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         irq_status_q <= '0;
      else
         irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
   end

   assign irq = |(irq_status_q & irq_enable_q);

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_ctrl_q <= rx_filter_pkg::RST_RX_FILTER_CONTROL;
         seed_ctrl_q <= rx_filter_pkg::RST_ACK_FILTER_SEED_CONTROL;
      end
      else if (wr_en && wb_sel_i[0])
      begin
         if (idx == rx_filter_pkg::IDX_RX_FILTER_CONTROL)
            rx_ctrl_q <= wb_dat_i[7:0] & rx_filter_pkg::WMASK_RX_FILTER_CONTROL;
         if (idx == rx_filter_pkg::IDX_ACK_FILTER_SEED_CONTROL)
            seed_ctrl_q <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         irq_enable_q <= '0;
         pan_short_q <= rx_filter_pkg::RST_PAN_SHORT;
         ext_lo_q <= rx_filter_pkg::RST_EXT_ADDR;
         ext_hi_q <= rx_filter_pkg::RST_EXT_ADDR;
      end
      else if (wr_en)
      begin
         if (idx == rx_filter_pkg::IDX_IRQ_ENABLE && wb_sel_i[0])
            irq_enable_q <= wb_dat_i[rx_filter_pkg::IRQ_W-1:0];
         if (idx == rx_filter_pkg::IDX_PAN_SHORT)
            pan_short_q <= (pan_short_q & ~wmask) | wdata_m;
         if (idx == rx_filter_pkg::IDX_EXT_ADDR_LO)
            ext_lo_q <= (ext_lo_q & ~wmask) | wdata_m;
         if (idx == rx_filter_pkg::IDX_EXT_ADDR_HI)
            ext_hi_q <= (ext_hi_q & ~wmask) | wdata_m;
      end
   end

   // ----------------------------------------
   // Wishbone answer
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ack_q <= 1'b0;
      else
         ack_q <= req && !ack_q;
   end

   assign wb_ack_o = ack_q;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata_q <= 32'h00000000;
      else if (req && !ack_q)
      begin
         unique case (idx)
            rx_filter_pkg::IDX_RX_FILTER_CONTROL: rdata_q <= {24'h000000, rx_ctrl_q};
            rx_filter_pkg::IDX_ACK_FILTER_SEED_CONTROL: rdata_q <= {24'h000000, seed_ctrl_q};
            rx_filter_pkg::IDX_IRQ_STATUS: rdata_q <= {29'h00000000, irq_status_q};
            rx_filter_pkg::IDX_IRQ_ENABLE: rdata_q <= {29'h00000000, irq_enable_q};
            rx_filter_pkg::IDX_PAN_SHORT: rdata_q <= pan_short_q;
            rx_filter_pkg::IDX_EXT_ADDR_LO: rdata_q <= ext_lo_q;
            rx_filter_pkg::IDX_EXT_ADDR_HI: rdata_q <= ext_hi_q;
            rx_filter_pkg::IDX_RX_STATUS: rdata_q <= {31'h00000000, crc_valid_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   assign wb_dat_o = rdata_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_drop_reserved;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && frm_phr_ok && reserved_type && !upload_en |=> !frame_done_irq && !address_hit_irq && reserved_drop;
   endproperty
   a_drop_reserved: assert property (p_drop_reserved) else $error("Reserved frame not dropped");
   property p_res_unfiltered;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && frm_phr_ok && reserved_type && upload_en && !filter_en && !promisc
      |=> frame_done_irq == $past(frm_fcs_ok) && !address_hit_irq && !ack_send;
   endproperty
   a_res_unfiltered: assert property (p_res_unfiltered) else $error("Unfiltered reserved frame mishandled");
   property p_ack_needs_done;
      @(posedge clk) disable iff (!rst_n)
      ack_send |-> frame_done_irq && address_hit_irq;
   endproperty
   a_ack_needs_done: assert property (p_ack_needs_done) else $error("Ack without frame done");
   property p_ack_disabled;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && ack_dis |=> !ack_send;
   endproperty
   a_ack_disabled: assert property (p_ack_disabled) else $error("Ack sent while disabled");
   property p_promisc_done;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && frm_phr_ok && promisc && !(reserved_type && !upload_en) |=> frame_done_irq;
   endproperty
   a_promisc_done: assert property (p_promisc_done) else $error("Promiscuous frame not finished");
   property p_crc_flag;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && frm_phr_ok |=> crc_valid_q == $past(frm_fcs_ok);
   endproperty
   a_crc_flag: assert property (p_crc_flag) else $error("CRC flag not updated");
   property p_version_reject;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && fv_limit != rx_filter_pkg::FVL_ANY && frm_version > fv_limit |=> !address_hit_irq && !ack_send;
   endproperty
   a_version_reject: assert property (p_version_reject) else $error("Frame over version limit passed");
   property p_ack_version;
      @(posedge clk) disable iff (!rst_n)
      ack_send |-> ack_fcf[13:12] == 2'h0 && ack_fcf[2:0] == rx_filter_pkg::FT_ACK;
   endproperty
   a_ack_version: assert property (p_ack_version) else $error("Ack frame version not zero");
   property p_no_ack_type;
      @(posedge clk) disable iff (!rst_n)
      frm_valid && (frm_type == rx_filter_pkg::FT_ACK || !(dst_present || src_present)) |=> !address_hit_irq;
   endproperty
   a_no_ack_type: assert property (p_no_ack_type) else $error("Ack or unaddressed frame matched");
   property p_reserved_bit;
      @(posedge clk) disable iff (!rst_n)
      wr_en && idx == rx_filter_pkg::IDX_RX_FILTER_CONTROL |=> rx_ctrl_q[rx_filter_pkg::RFC_RESERVED_RO] == 1'b0;
   endproperty
   a_reserved_bit: assert property (p_reserved_bit) else $error("Reserved control bit set");
   property p_irq_raise;
      @(posedge clk) disable iff (!rst_n)
      frame_done_irq && irq_enable_q[rx_filter_pkg::IRQ_FRAME_DONE] |=> irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("Interrupt not raised");
endmodule

// *** sim/frame_pkg.sv ***
package frame_pkg;
   typedef struct packed {
      logic phr;
      logic fcs;
      logic [2:0] ftype;
      logic [1:0] ver;
      logic areq;
      logic [1:0] dm;
      logic [1:0] sm;
      logic [15:0] dpan;
      logic [63:0] dadr;
      logic [15:0] span;
      logic [7:0] seq;
   } frame_s;
endpackage

// *** sim/frame_source.sv ***
module frame_source (
   input wire logic clk,
   output logic valid,
   output frame_pkg::frame_s frm
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Remote transmitter, one parsed frame per call
   // ----------------------------------------
   initial
   begin
      valid = 1'b0;
      frm = '0;
   end
   task automatic send(input frame_pkg::frame_s f);
      @(posedge clk);
      valid <= 1'b1;
      frm <= f;
      @(posedge clk);
      valid <= 1'b0;
      // Fields mean nothing outside a frame, so they are scrambled
      frm <= ~f;
   endtask
endmodule

// *** sim/rx_frame_filter_ack_control_tb.sv ***
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module rx_frame_filter_ack_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CTL = rx_filter_pkg::IDX_RX_FILTER_CONTROL;
   localparam logic [7:0] SEED = rx_filter_pkg::IDX_ACK_FILTER_SEED_CONTROL;
   localparam logic [7:0] STA = rx_filter_pkg::IDX_IRQ_STATUS;
   localparam logic [7:0] CLR = rx_filter_pkg::IDX_IRQ_CLEAR;
   localparam logic [7:0] ENA = rx_filter_pkg::IDX_IRQ_ENABLE;
   localparam logic [7:0] CRC = rx_filter_pkg::IDX_RX_STATUS;
   localparam logic [2:0] DATA = rx_filter_pkg::FT_DATA;
   localparam logic [1:0] SH = rx_filter_pkg::AM_SHORT;
   localparam logic [15:0] P = 16'h1234;
   localparam logic [15:0] Q = 16'h1235;
   localparam logic [63:0] S = 64'h0042;
   localparam logic [63:0] X = 64'h0123456789abcdef;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, valid, done, hit, drop, asend, irq;
   logic [15:0] fcf;
   logic [7:0] aseq;
   logic [7:0] seq_n = 8'h00;
   frame_pkg::frame_s frm, last;
   int errors = 0;
   int check_count = 0;

   always #5 clk = ~clk;

   frame_source src (.clk(clk), .valid(valid), .frm(frm));
   rx_frame_filter_ack_control #(.ADDR_W(8)) dut (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .frm_valid(valid),
      .frm_phr_ok(frm.phr), .frm_fcs_ok(frm.fcs), .frm_type(frm.ftype), .frm_version(frm.ver),
      .frm_ack_req(frm.areq), .frm_dst_mode(frm.dm), .frm_src_mode(frm.sm), .frm_dst_pan(frm.dpan),
      .frm_dst_addr(frm.dadr), .frm_src_pan(frm.span), .frm_seq(frm.seq), .frame_done_irq(done),
      .address_hit_irq(hit), .reserved_drop(drop), .ack_send(asend), .ack_fcf(fcf), .ack_seq(aseq),
      .irq(irq)
   );

   // ----------------------------------------
   // Bus cycles and frame checks
   // ----------------------------------------
   task automatic wb(input logic [7:0] idx, input logic w, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= idx << 2;
      sel <= 4'hf;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         errors++;
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      wb(idx, 1'b1, d, r);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] r;
      wb(idx, 1'b0, 32'h0, r);
      `CHK(r, e)
   endtask

   function automatic frame_pkg::frame_s mk(logic [2:0] t, logic [15:0] dp = P, logic fcs = 1'b1,
         logic [1:0] v = 2'h0, logic [63:0] da = S, logic [1:0] dm = SH, logic [1:0] sm = 2'h0,
         logic [15:0] sp = 16'h0);
      seq_n++;
      return '{1'b1, fcs, t, v, 1'b1, dm, sm, dp, da, sp, seq_n};
   endfunction

   // Expected pattern is {frame done, address hit, reserved drop, ack send}
   task automatic fr(input frame_pkg::frame_s f, input logic [3:0] e);
      logic [3:0] got;
      last = f;
      src.send(f);
      @(negedge clk);
      got = {done, hit, drop, asend};
      `CHK(got, e)
   endtask

   task automatic complete_run();
      $display("errors=%0d check_count=%0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      frame_pkg::frame_s f;
      logic ok;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(CTL, 32'h0);
      rd(SEED, 32'h42);
      rd(8'h10, 32'h0);
      wr(CTL, 32'hff);
      rd(CTL, 32'hf7);
      wr(CTL, 32'h0);
      wr(rx_filter_pkg::IDX_PAN_SHORT, {P, S[15:0]});
      wr(rx_filter_pkg::IDX_EXT_ADDR_LO, X[31:0]);
      wr(rx_filter_pkg::IDX_EXT_ADDR_HI, X[63:32]);
      wr(ENA, 32'h1);
      fr(mk(DATA, P, 1'b1, 2'h1), 4'b1101);
      `CHK(fcf, 16'h0002)
      `CHK(aseq, last.seq)
      // Status bit is set one cycle after the event pulse
      @(negedge clk);
      `CHK(irq, 1'b1)
      rd(STA, 32'h3);
      wr(ENA, 32'h2);
      wr(CLR, 32'h2);
      @(negedge clk);
      `CHK(irq, 1'b0)
      rd(STA, 32'h1);
      wr(CLR, 32'h7);
      fr(mk(rx_filter_pkg::FT_COMMAND, P, 1'b1, 2'h0, X, rx_filter_pkg::AM_EXT), 4'b1101);
      fr(mk(DATA, 16'hffff, 1'b1, 2'h0, 64'hffff), 4'b1101);
      fr(mk(DATA, Q), 4'b0000);
      fr(mk(rx_filter_pkg::FT_ACK), 4'b0000);
      fr(mk(DATA, P, 1'b1, 2'h0, S, 2'h0, 2'h0, P), 4'b0000);
      fr(mk(rx_filter_pkg::FT_BEACON, P, 1'b1, 2'h0, S, 2'h0, SH, P), 4'b1100);
      for (int l = 0; l < 4; l++)
      begin
         wr(SEED, {24'h000000, 2'(l), 6'h02});
         for (int v = 0; v < 4; v++)
         begin
            ok = (l == 3) || (v <= l);
            fr(mk(DATA, P, 1'b1, 2'(v)), {ok, ok, 1'b0, ok});
         end
      end
      fr(mk(DATA, P, 1'b1, 2'h0, S, 2'h0, SH, P), 4'b0000);
      wr(SEED, 32'hca);
      fr(mk(DATA, P, 1'b1, 2'h0, S, 2'h0, SH, P), 4'b1101);
      fr(mk(DATA, P, 1'b1, 2'h0, S, 2'h0, SH, Q), 4'b0000);
      wr(SEED, 32'hc2);
      wr(CLR, 32'h7);
      for (int t = 4; t < 8; t++)
         fr(mk(3'(t)), 4'b0010);
      rd(STA, 32'h4);
      wr(CTL, 32'h10);
      fr(mk(3'h5, Q), 4'b1000);
      fr(mk(3'h6), 4'b1000);
      fr(mk(3'h4, P, 1'b0), 4'b0000);
      wr(CTL, 32'h30);
      fr(mk(3'h7), 4'b1101);
      fr(mk(3'h7, P, 1'b0), 4'b0100);
      fr(mk(3'h4, Q), 4'b0000);
      wr(SEED, 32'hd2);
      fr(mk(3'h4), 4'b1100);
      wr(CTL, 32'h02);
      fr(mk(DATA, Q, 1'b0), 4'b1000);
      rd(CRC, 32'h0);
      fr(mk(DATA), 4'b1100);
      wr(SEED, 32'hc2);
      fr(mk(DATA), 4'b1101);
      rd(CRC, 32'h1);
      wr(SEED, 32'he2);
      fr(mk(DATA), 4'b1101);
      `CHK(fcf, 16'h0012)
      wr(CTL, 32'h32);
      f = mk(3'h7);
      f.areq = 1'b0;
      fr(f, 4'b1100);
      f = mk(DATA, Q, 1'b0);
      f.phr = 1'b0;
      fr(f, 4'b0000);
      rd(CRC, 32'h1);
      complete_run();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule
